// [rtl/uri_usart_regs.sv]
// Register layer of the serial transceiver
// Operation
// - Data port writes fill transmit holding buffer; reads return receive FIFO.
// - Five to seven bit characters drop upper bits; received upper bits read zero.
// - Data writes while buffer-empty flag is clear are discarded.
// - Enabled transmitter loads the buffer into an empty shifter and sends it.
// - Receive FIFO is two deep and advances on each data port read while it holds data.
// - Receive-complete flag shows unread data; receiver disable flushes and clears it.
// - Transmit-complete sets after last frame with empty buffer; cleared by ack or one.
// - Buffer-empty flag is one when buffer accepts data, and after reset.
// - Framing error shows first stop bit zero of next buffered character.
// - Overrun sets on start bit while FIFO full and shifter holds a character.
// - Parity error shows failed check of next buffered character.
// - Double speed halves samples per bit, asynchronous mode only.
// - Multiprocessor filter drops every frame not marked as address.
// - Each interrupt needs its enable, global enable and its flag.
// - Receiver enable takes the receive pin; disable flushes FIFO and errors.
// - Transmitter disable waits for empty shifter and buffer, then frees pin.
// - Character size comes from high bit in B and two bits in C.
// - Mode bits select asynchronous or synchronous; SPI code 11 runs as synchronous slave; 10 reserved.
// - Size codes give five to nine bits; 100 to 110 reserved.
// - Parity field selects off, even or odd; mismatch flags parity error.
// - Stop select inserts one or two stop bits; receiver ignores it.
// - Synchronous clock polarity picks transmit change and receive sample edges.
module uri_usart_regs
  import uri_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic [7:0] io_addr_i,
  input wire logic io_wr_i,
  input wire logic io_rd_i,
  input wire logic [7:0] io_wdata_i,
  output logic [7:0] io_rdata_o,
  input wire logic global_irq_en_i,
  input wire logic tx_complete_irq_ack_i,
  output logic rx_complete_irq_o,
  output logic tx_complete_irq_o,
  output logic tx_empty_irq_o,
  input wire logic serial_rx_pin_i,
  input wire logic sync_clock_pin_i,
  output logic serial_tx_pin_o,
  output logic serial_tx_override_o,
  output logic serial_rx_override_o
);
  uri_link_if lnk ();

  logic [7:0] control_b_r;
  logic [7:0] control_c_r;
  logic double_speed_bit_r;
  logic multiproc_filter_bit_r;
  logic tx_complete_flag_r;
  logic tx_full_r;
  logic [8:0] tx_holding_buffer_r;
  logic tx_start_r;
  logic tx_active_r;
  logic [10:0] rx_holding_fifo_r [2];
  logic rd_ptr_r;
  logic wr_ptr_r;
  logic [1:0] fifo_cnt_r;
  logic [10:0] wait_r;
  logic wait_full_r;
  logic overrun_flag_r;
  logic [1:0] rx_pin_sync_r;
  logic [1:0] xck_sync_r;
  logic wr_a;
  logic wr_b;
  logic wr_c;
  logic wr_data;
  logic rd_data;
  logic rx_en;
  logic [2:0] size_code;
  logic [3:0] char_bits;
  logic [8:0] char_mask;
  logic [10:0] head;
  logic [10:0] frame;
  logic frame_is_addr;
  logic accept;
  logic pop;
  logic room;
  logic push;
  logic [10:0] push_word;
  logic wait_load;
  logic rx_complete_flag;
  logic tx_buffer_empty_flag;
  logic [7:0] status_a;
  logic [1:0] mode;

  assign wr_a = io_wr_i && io_addr_i == ADDR_STATUS_A;
  assign wr_b = io_wr_i && io_addr_i == ADDR_CONTROL_B;
  assign wr_c = io_wr_i && io_addr_i == ADDR_CONTROL_C;
  assign wr_data = io_wr_i && io_addr_i == ADDR_DATA_PORT;
  assign rd_data = io_rd_i && io_addr_i == ADDR_DATA_PORT;
  assign rx_en = control_b_r[B_RXEN];
  assign mode = control_c_r[C_MODE +: 2];
  assign size_code = {control_b_r[B_SIZE_HI], control_c_r[C_SIZE_LO +: 2]};

  // Reserved size codes fall back to eight bits
  always_comb begin
    case (size_code)
      3'h0: char_bits = 4'h5;
      3'h1: char_bits = 4'h6;
      3'h2: char_bits = 4'h7;
      3'h7: char_bits = 4'h9;
      default: char_bits = 4'h8;
    endcase
  end
  assign char_mask = 9'h1ff >> (4'h9 - char_bits);

  assign lnk.char_bits = char_bits;
  assign lnk.parity_mode = control_c_r[C_PARITY +: 2];
  assign lnk.stop_two = control_c_r[C_STOP2];
  // SPI code runs as synchronous slave; reserved code as asynchronous
  assign lnk.sync_mode = (mode == MODE_SYNC) || (mode == MODE_SPI);
  assign lnk.clk_pol = control_c_r[C_POL];
  assign lnk.double_speed = double_speed_bit_r && !lnk.sync_mode;
  assign lnk.rx_enable = rx_en;
  assign lnk.rx_line = rx_pin_sync_r[1];
  assign lnk.xck_level = xck_sync_r[1];
  assign lnk.tx_start = tx_start_r;
  assign lnk.tx_word = tx_holding_buffer_r;

  uri_serial_engine u_engine (
    .core_clk_i(core_clk_i),
    .reset_n_i(reset_n_i),
    .lnk(lnk)
  );

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      rx_pin_sync_r <= 2'h3;
      xck_sync_r <= 2'h0;
    end else begin
      rx_pin_sync_r <= {rx_pin_sync_r[0], serial_rx_pin_i};
      xck_sync_r <= {xck_sync_r[0], sync_clock_pin_i};
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      control_b_r <= RESET_CONTROL_B;
      control_c_r <= RESET_CONTROL_C;
      double_speed_bit_r <= RESET_STATUS_A[A_DBL];
      multiproc_filter_bit_r <= RESET_STATUS_A[A_MPCM];
    end else begin
      if (wr_b) begin
        control_b_r <= io_wdata_i & ~(8'h01 << B_RX9);
      end
      if (wr_c) begin
        control_c_r <= io_wdata_i;
      end
      if (wr_a) begin
        double_speed_bit_r <= io_wdata_i[A_DBL];
        multiproc_filter_bit_r <= io_wdata_i[A_MPCM];
      end
    end
  end

  // Transmit holding buffer and hand-off to the shifter
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      tx_full_r <= 1'b0;
      tx_holding_buffer_r <= 9'h000;
      tx_start_r <= 1'b0;
    end else begin
      tx_start_r <= 1'b0;
      if (tx_active_r && tx_full_r && !lnk.tx_busy && !tx_start_r) begin
        tx_start_r <= 1'b1;
        tx_full_r <= 1'b0;
      end
      if (wr_data && !tx_full_r) begin
        tx_holding_buffer_r <= {control_b_r[B_TX9], io_wdata_i} & char_mask;
        tx_full_r <= 1'b1;
      end
    end
  end

  // Pin stays claimed until all pending data has gone out
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      tx_active_r <= 1'b0;
    end else if (control_b_r[B_TXEN]) begin
      tx_active_r <= 1'b1;
    end else if (!tx_full_r && !lnk.tx_busy && !tx_start_r) begin
      tx_active_r <= 1'b0;
    end
  end

  // A new completion beats a same-cycle clear
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      tx_complete_flag_r <= RESET_STATUS_A[A_TXC];
    end else if (lnk.tx_done && !tx_full_r && !tx_start_r) begin
      tx_complete_flag_r <= 1'b1;
    end else if ((wr_a && io_wdata_i[A_TXC]) || tx_complete_irq_ack_i) begin
      tx_complete_flag_r <= 1'b0;
    end
  end

  // Receive path: two-entry FIFO plus the character held in the shifter
  assign frame = {lnk.rx_parity_err, lnk.rx_frame_err, lnk.rx_word};
  assign frame_is_addr = (char_bits == 4'h9) ? lnk.rx_word[8]
                                             : !lnk.rx_frame_err;
  assign accept = lnk.rx_valid && !(multiproc_filter_bit_r && !frame_is_addr);
  assign pop = rd_data && fifo_cnt_r != 2'h0;
  assign room = (fifo_cnt_r != 2'h2) || pop;
  assign push = (pop && wait_full_r) || (accept && room && !wait_full_r);
  assign push_word = wait_full_r ? wait_r : frame;
  assign wait_load = accept && !(room && !wait_full_r);
  assign head = rx_holding_fifo_r[rd_ptr_r];

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i || !rx_en) begin
      fifo_cnt_r <= 2'h0;
      rd_ptr_r <= 1'b0;
      wr_ptr_r <= 1'b0;
      wait_full_r <= 1'b0;
    end else begin
      fifo_cnt_r <= fifo_cnt_r + {1'b0, push} - {1'b0, pop};
      rd_ptr_r <= rd_ptr_r ^ pop;
      wr_ptr_r <= wr_ptr_r ^ push;
      wait_full_r <= wait_load || (wait_full_r && !pop);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      wait_r <= 11'h000;
    end else if (wait_load) begin
      wait_r <= frame;
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_entry
      always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
          rx_holding_fifo_r[gi] <= 11'h000;
        end else if (push && wr_ptr_r == 1'(gi)) begin
          rx_holding_fifo_r[gi] <= push_word;
        end
      end
    end
  endgenerate

  // Overrun set wins over the clear by a data read
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i || !rx_en) begin
      overrun_flag_r <= 1'b0;
    end else if (lnk.rx_start_seen && fifo_cnt_r == 2'h2 && wait_full_r) begin
      overrun_flag_r <= 1'b1;
    end else if (rd_data) begin
      overrun_flag_r <= 1'b0;
    end
  end

  assign rx_complete_flag = fifo_cnt_r != 2'h0;
  assign tx_buffer_empty_flag = !tx_full_r;
  always_comb begin
    status_a = 8'h00;
    status_a[A_RXC] = rx_complete_flag;
    status_a[A_TXC] = tx_complete_flag_r;
    status_a[A_UDRE] = tx_buffer_empty_flag;
    status_a[A_FE] = rx_complete_flag && head[9];
    status_a[A_DOR] = overrun_flag_r;
    status_a[A_PE] = rx_complete_flag && head[10];
    status_a[A_DBL] = double_speed_bit_r;
    status_a[A_MPCM] = multiproc_filter_bit_r;
  end

  // Read data registered so every output leaves a flop
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      io_rdata_o <= 8'h00;
    end else if (io_rd_i) begin
      case (io_addr_i)
        ADDR_STATUS_A: io_rdata_o <= status_a;
        ADDR_CONTROL_B: io_rdata_o <= control_b_r |
          ({7'h00, rx_complete_flag && head[8]} << B_RX9);
        ADDR_CONTROL_C: io_rdata_o <= control_c_r;
        ADDR_DATA_PORT: io_rdata_o <= rx_complete_flag ? head[7:0] : 8'h00;
        default: io_rdata_o <= 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      rx_complete_irq_o <= 1'b0;
      tx_complete_irq_o <= 1'b0;
      tx_empty_irq_o <= 1'b0;
    end else begin
      rx_complete_irq_o <= control_b_r[B_RXCIE] && global_irq_en_i &&
        rx_complete_flag;
      tx_complete_irq_o <= control_b_r[B_TXCIE] && global_irq_en_i &&
        tx_complete_flag_r;
      tx_empty_irq_o <= control_b_r[B_UDRIE] && global_irq_en_i &&
        tx_buffer_empty_flag;
    end
  end

  // Port value is high while the transmitter does not own the pin
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      serial_tx_pin_o <= 1'b1;
      serial_tx_override_o <= 1'b0;
      serial_rx_override_o <= 1'b0;
    end else begin
      serial_tx_pin_o <= tx_active_r ? lnk.tx_line : 1'b1;
      serial_tx_override_o <= tx_active_r;
      serial_rx_override_o <= rx_en;
    end
  end
endmodule

// [rtl/uri_pkg.sv]
// Constants and types shared by the serial register block
package uri_pkg;
  localparam logic [7:0] ADDR_STATUS_A = 8'hc0;
  localparam logic [7:0] ADDR_CONTROL_B = 8'hc1;
  localparam logic [7:0] ADDR_CONTROL_C = 8'hc2;
  localparam logic [7:0] ADDR_DATA_PORT = 8'hc6;
  localparam logic [7:0] RESET_STATUS_A = 8'h20;
  localparam logic [7:0] RESET_CONTROL_B = 8'h00;
  localparam logic [7:0] RESET_CONTROL_C = 8'h06;
  localparam int A_RXC = 7;
  localparam int A_TXC = 6;
  localparam int A_UDRE = 5;
  localparam int A_FE = 4;
  localparam int A_DOR = 3;
  localparam int A_PE = 2;
  localparam int A_DBL = 1;
  localparam int A_MPCM = 0;
  localparam int B_RXCIE = 7;
  localparam int B_TXCIE = 6;
  localparam int B_UDRIE = 5;
  localparam int B_RXEN = 4;
  localparam int B_TXEN = 3;
  localparam int B_SIZE_HI = 2;
  localparam int B_RX9 = 1;
  localparam int B_TX9 = 0;
  localparam int C_MODE = 6;
  localparam int C_PARITY = 4;
  localparam int C_STOP2 = 3;
  localparam int C_SIZE_LO = 1;
  localparam int C_POL = 0;
  localparam logic [1:0] MODE_ASYNC = 2'h0;
  localparam logic [1:0] MODE_SYNC = 2'h1;
  localparam logic [1:0] MODE_SPI = 2'h3;
  localparam logic [1:0] PARITY_OFF = 2'h0;
  localparam logic [1:0] PARITY_EVEN = 2'h2;
  localparam logic [1:0] PARITY_ODD = 2'h3;
  localparam logic [3:0] LAST_SAMPLE_NORMAL = 4'hf;
  localparam logic [3:0] LAST_SAMPLE_DOUBLE = 4'h7;
  localparam logic [3:0] MID_SAMPLE_NORMAL = 4'h7;
  localparam logic [3:0] MID_SAMPLE_DOUBLE = 4'h3;
  localparam logic [7:0] SAMPLE_CYCLES = 8'h1b;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_START = 5'h02,
    ST_DATA = 5'h04,
    ST_PARITY = 5'h08,
    ST_STOP = 5'h10
  } uri_frame_state_t;
endpackage

// [rtl/uri_link_if.sv]
// Signals between the register layer and the serial engine
interface uri_link_if;
  logic tx_start;
  logic [8:0] tx_word;
  logic tx_busy;
  logic tx_done;
  logic tx_line;
  logic rx_enable;
  logic rx_line;
  logic xck_level;
  logic rx_valid;
  logic [8:0] rx_word;
  logic rx_frame_err;
  logic rx_parity_err;
  logic rx_start_seen;
  logic [3:0] char_bits;
  logic [1:0] parity_mode;
  logic stop_two;
  logic sync_mode;
  logic clk_pol;
  logic double_speed;
  modport ctrl (output tx_start, tx_word, rx_enable, rx_line, xck_level,
    char_bits, parity_mode, stop_two, sync_mode, clk_pol, double_speed,
    input tx_busy, tx_done, tx_line, rx_valid, rx_word, rx_frame_err,
    rx_parity_err, rx_start_seen);
  modport eng (input tx_start, tx_word, rx_enable, rx_line, xck_level,
    char_bits, parity_mode, stop_two, sync_mode, clk_pol, double_speed,
    output tx_busy, tx_done, tx_line, rx_valid, rx_word, rx_frame_err,
    rx_parity_err, rx_start_seen);
endinterface

// [rtl/uri_serial_engine.sv]
// Frame shifter for transmit and receive
module uri_serial_engine
  import uri_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  uri_link_if.eng lnk
);
  logic [7:0] presc_r;
  logic tick;
  logic xck_d_r;
  logic rx_line_d_r;
  logic tx_edge;
  logic rx_edge;
  logic [3:0] last_s;
  logic [3:0] mid_s;
  uri_frame_state_t tx_st_r;
  logic [3:0] tx_cnt_r;
  logic [3:0] tx_idx_r;
  logic [8:0] tx_sh_r;
  logic tx_par_r;
  logic tx_stops_r;
  logic tx_step;
  uri_frame_state_t rx_st_r;
  logic [3:0] rx_cnt_r;
  logic [3:0] rx_idx_r;
  logic [8:0] rx_sh_r;
  logic rx_par_r;
  logic rx_samp;
  logic par_on;

  assign tick = (presc_r == SAMPLE_CYCLES - 8'h01);
  assign last_s = lnk.double_speed ? LAST_SAMPLE_DOUBLE : LAST_SAMPLE_NORMAL;
  assign mid_s = lnk.double_speed ? MID_SAMPLE_DOUBLE : MID_SAMPLE_NORMAL;
  assign tx_edge = lnk.clk_pol ? (xck_d_r & ~lnk.xck_level)
                               : (~xck_d_r & lnk.xck_level);
  assign rx_edge = lnk.clk_pol ? (~xck_d_r & lnk.xck_level)
                               : (xck_d_r & ~lnk.xck_level);
  assign tx_step = lnk.sync_mode ? tx_edge : (tick && tx_cnt_r == last_s);
  assign rx_samp = lnk.sync_mode ? rx_edge : (tick && rx_cnt_r == mid_s);
  assign par_on = lnk.parity_mode[1];
  assign lnk.tx_busy = (tx_st_r != ST_IDLE);

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      presc_r <= 8'h00;
      xck_d_r <= 1'b0;
      rx_line_d_r <= 1'b1;
    end else begin
      presc_r <= tick ? 8'h00 : presc_r + 8'h01;
      xck_d_r <= lnk.xck_level;
      rx_line_d_r <= lnk.rx_line;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i || tx_st_r == ST_IDLE || tx_step) begin
      tx_cnt_r <= 4'h0;
    end else if (tick) begin
      tx_cnt_r <= tx_cnt_r + 4'h1;
    end
  end

  // Start low, data LSB first, optional parity, one or two stops
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      tx_st_r <= ST_IDLE;
      lnk.tx_line <= 1'b1;
      lnk.tx_done <= 1'b0;
      tx_idx_r <= 4'h0;
      tx_sh_r <= 9'h000;
      tx_par_r <= 1'b0;
      tx_stops_r <= 1'b0;
    end else begin
      lnk.tx_done <= 1'b0;
      case (tx_st_r)
        ST_IDLE: begin
          lnk.tx_line <= 1'b1;
          if (lnk.tx_start) begin
            tx_sh_r <= lnk.tx_word;
            tx_par_r <= (^lnk.tx_word) ^ lnk.parity_mode[0];
            lnk.tx_line <= 1'b0;
            tx_st_r <= ST_START;
          end
        end
        ST_START: begin
          if (tx_step) begin
            lnk.tx_line <= tx_sh_r[0];
            tx_sh_r <= tx_sh_r >> 1;
            tx_idx_r <= 4'h1;
            tx_st_r <= ST_DATA;
          end
        end
        ST_DATA: begin
          if (tx_step) begin
            if (tx_idx_r == lnk.char_bits) begin
              lnk.tx_line <= par_on ? tx_par_r : 1'b1;
              tx_stops_r <= lnk.stop_two;
              tx_st_r <= par_on ? ST_PARITY : ST_STOP;
            end else begin
              lnk.tx_line <= tx_sh_r[0];
              tx_sh_r <= tx_sh_r >> 1;
              tx_idx_r <= tx_idx_r + 4'h1;
            end
          end
        end
        ST_PARITY: begin
          if (tx_step) begin
            lnk.tx_line <= 1'b1;
            tx_stops_r <= lnk.stop_two;
            tx_st_r <= ST_STOP;
          end
        end
        ST_STOP: begin
          if (tx_step) begin
            if (tx_stops_r) begin
              tx_stops_r <= 1'b0;
            end else begin
              tx_st_r <= ST_IDLE;
              lnk.tx_done <= 1'b1;
            end
          end
        end
        default: tx_st_r <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i || rx_st_r == ST_IDLE || (tick && rx_cnt_r == last_s)) begin
      rx_cnt_r <= 4'h0;
    end else if (tick) begin
      rx_cnt_r <= rx_cnt_r + 4'h1;
    end
  end

  // Only the first stop bit is checked
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i || !lnk.rx_enable) begin
      rx_st_r <= ST_IDLE;
      lnk.rx_valid <= 1'b0;
      lnk.rx_start_seen <= 1'b0;
      lnk.rx_word <= 9'h000;
      lnk.rx_frame_err <= 1'b0;
      lnk.rx_parity_err <= 1'b0;
      rx_idx_r <= 4'h0;
      rx_sh_r <= 9'h000;
      rx_par_r <= 1'b0;
    end else begin
      lnk.rx_valid <= 1'b0;
      lnk.rx_start_seen <= 1'b0;
      case (rx_st_r)
        ST_IDLE: begin
          rx_sh_r <= 9'h000;
          rx_idx_r <= 4'h0;
          if (lnk.sync_mode && rx_edge && !lnk.rx_line) begin
            lnk.rx_start_seen <= 1'b1;
            rx_st_r <= ST_DATA;
          // Falling edge only, so a low stop bit never restarts a frame
          end else if (!lnk.sync_mode && rx_line_d_r && !lnk.rx_line) begin
            rx_st_r <= ST_START;
          end
        end
        ST_START: begin
          if (rx_samp) begin
            lnk.rx_start_seen <= !lnk.rx_line;
            rx_st_r <= lnk.rx_line ? ST_IDLE : ST_DATA;
          end
        end
        ST_DATA: begin
          if (rx_samp) begin
            rx_sh_r[rx_idx_r] <= lnk.rx_line;
            rx_idx_r <= rx_idx_r + 4'h1;
            if (rx_idx_r == lnk.char_bits - 4'h1) begin
              rx_st_r <= par_on ? ST_PARITY : ST_STOP;
            end
          end
        end
        ST_PARITY: begin
          if (rx_samp) begin
            rx_par_r <= lnk.rx_line;
            rx_st_r <= ST_STOP;
          end
        end
        ST_STOP: begin
          if (rx_samp) begin
            lnk.rx_valid <= 1'b1;
            lnk.rx_word <= rx_sh_r;
            lnk.rx_frame_err <= !lnk.rx_line;
            lnk.rx_parity_err <= par_on &&
              (rx_par_r != ((^rx_sh_r) ^ lnk.parity_mode[0]));
            rx_st_r <= ST_IDLE;
          end
        end
        default: rx_st_r <= ST_IDLE;
      endcase
    end
  end
endmodule

// [sim/uri_usart_props.sv]
// Port-level checker for the serial register block
module uri_usart_props
  import uri_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic [7:0] io_addr_i,
  input wire logic io_wr_i,
  input wire logic io_rd_i,
  input wire logic [7:0] io_wdata_i,
  input wire logic [7:0] io_rdata_o,
  input wire logic global_irq_en_i,
  input wire logic rx_complete_irq_o,
  input wire logic tx_complete_irq_o,
  input wire logic tx_empty_irq_o,
  input wire logic serial_tx_pin_o,
  input wire logic serial_tx_override_o,
  input wire logic serial_rx_override_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  logic [7:0] ctl_c_r;
  logic unmapped;
  assign unmapped = !(io_addr_i inside {ADDR_STATUS_A, ADDR_CONTROL_B,
    ADDR_CONTROL_C, ADDR_DATA_PORT});
  // Shadow of the control C writes, to judge its read-back
  always_ff @(posedge core_clk_i) begin
    if (!reset_n_i) begin
      ctl_c_r <= RESET_CONTROL_C;
    end else if (io_wr_i && io_addr_i == ADDR_CONTROL_C) begin
      ctl_c_r <= io_wdata_i;
    end
  end
  sequence s_rx_on;
    io_wr_i && io_addr_i == ADDR_CONTROL_B && io_wdata_i[B_RXEN];
  endsequence
  sequence s_c_read;
    io_rd_i && !io_wr_i && io_addr_i == ADDR_CONTROL_C;
  endsequence
  rx_irq_gate_a: assert property (rx_complete_irq_o |->
    $past(global_irq_en_i)) else $error("rx irq without global enable");
  tx_irq_gate_a: assert property (tx_complete_irq_o |->
    $past(global_irq_en_i)) else $error("tx irq without global enable");
  empty_irq_off_a: assert property (!global_irq_en_i [*2] |->
    !tx_empty_irq_o) else $error("empty irq while globally off");
  unmapped_read_a: assert property (io_rd_i && unmapped |=>
    io_rdata_o == 8'h00) else $error("unmapped read not zero");
  rdata_hold_a: assert property (!io_rd_i |=>
    $stable(io_rdata_o)) else $error("read data moved without read");
  ctl_c_read_a: assert property (s_c_read |=>
    io_rdata_o == ctl_c_r) else $error("control C read-back wrong");
  tx_idle_high_a: assert property (!serial_tx_override_o |->
    serial_tx_pin_o) else $error("tx pin low while released");
  rx_pin_own_a: assert property (s_rx_on |->
    ##[1:2] serial_rx_override_o) else $error("rx pin not taken");
endmodule

bind uri_usart_regs uri_usart_props chk_u (.*);

// [sim/uri_remote_peer.sv]
// Remote serial peer: sends frames and captures what it hears
module uri_remote_peer #(
  parameter int BIT = 432
) (
  input wire logic core_clk_i,
  input wire logic line_i,
  output logic line_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [8:0] got_q[$];
  int nbits = 8;
  initial line_o = 1'b1;
  task automatic bit_out(input logic b);
    line_o <= b;
    repeat (BIT) @(posedge core_clk_i);
  endtask
  // Bad parity and low stop only when a scenario asks
  task automatic send(input logic [8:0] d, input logic pe, bp, sb);
    bit_out(1'b0);
    for (int i = 0; i < nbits; i++) bit_out(d[i]);
    if (pe) bit_out(^(d & 9'((1 << nbits) - 1)) ^ bp);
    bit_out(sb);
    bit_out(1'b1);
  endtask
  // Low stop logged as 1ff, never a legal narrow value
  always begin
    logic [8:0] w;
    @(negedge line_i);
    w = 9'h000;
    repeat (BIT / 2) @(posedge core_clk_i);
    for (int i = 0; i < nbits; i++) begin
      repeat (BIT) @(posedge core_clk_i);
      w[i] = line_i;
    end
    repeat (BIT) @(posedge core_clk_i);
    got_q.push_back(line_i ? w : 9'h1ff);
  end
endmodule

// [sim/usart_register_interface_test.sv]
// Self-checking bench for the serial register block
module usart_register_interface_test
  import uri_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int BIT = 16 * SAMPLE_CYCLES;
  localparam logic [7:0] RA = ADDR_STATUS_A, RB = ADDR_CONTROL_B;
  localparam logic [7:0] RC = ADDR_CONTROL_C, RD = ADDR_DATA_PORT;
  logic core_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [7:0] io_addr_i = 8'h00;
  logic io_wr_i = 1'b0;
  logic io_rd_i = 1'b0;
  logic [7:0] io_wdata_i = 8'h00;
  logic global_irq_en_i = 1'b0;
  logic tx_complete_irq_ack_i = 1'b0;
  logic sync_clock_pin_i = 1'b0;
  logic [7:0] io_rdata_o;
  logic rx_complete_irq_o, tx_complete_irq_o, tx_empty_irq_o;
  logic serial_rx_pin_i, serial_tx_pin_o;
  logic serial_tx_override_o, serial_rx_override_o;
  int fails = 0;
  int cmp_count = 0;
  always #10 core_clk_i = ~core_clk_i;
  uri_usart_regs dut_u (.*);
  uri_remote_peer #(.BIT(BIT)) peer_u (.core_clk_i(core_clk_i),
    .line_i(serial_tx_pin_o), .line_o(serial_rx_pin_i));
  // Strobe dropped at the taking edge, so each access costs two cycles
  task automatic wr(input logic [7:0] a, d);
    io_addr_i <= a;
    io_wdata_i <= d;
    io_wr_i <= 1'b1;
    @(posedge core_clk_i);
    io_wr_i <= 1'b0;
    @(posedge core_clk_i);
  endtask
  task automatic cmp(input logic [8:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk(input logic [7:0] a, m, e);
    io_addr_i <= a;
    io_rd_i <= 1'b1;
    @(posedge core_clk_i);
    io_rd_i <= 1'b0;
    @(posedge core_clk_i);
    cmp({1'b0, io_rdata_o & m}, {1'b0, e});
  endtask
  task automatic t_regs();
    logic [7:0] m[3] = '{8'h36, 8'h6d, 8'hc0};
    chk(RA, 8'hff, RESET_STATUS_A);
    chk(RB, 8'hff, RESET_CONTROL_B);
    chk(RC, 8'hff, RESET_CONTROL_C);
    wr(8'hc3, 8'hff);
    chk(8'hc3, 8'hff, 8'h00);
    wr(RA, 8'hff);
    chk(RA, 8'h1f, 8'h03);
    wr(RA, 8'h00);
    foreach (m[i]) begin
      wr(RC, m[i]);
      chk(RC, 8'hff, m[i]);
    end
  endtask
  task automatic t_tx();
    wr(RC, 8'h06);
    wr(RB, 8'h08);
    wr(RD, 8'ha5);
    repeat (4) @(posedge core_clk_i);
    wr(RD, 8'h5a);
    chk(RA, 8'h20, 8'h00);
    wr(RD, 8'h33);
    wr(RB, 8'h00);
    cmp(serial_tx_override_o, 1'b1);
    for (int i = 0; i < 24 * BIT && peer_u.got_q.size() < 2; i++)
      @(posedge core_clk_i);
    repeat (2 * BIT) @(posedge core_clk_i);
    cmp(9'(peer_u.got_q.size()), 9'd2);
    cmp(peer_u.got_q[0], 9'h0a5);
    cmp(peer_u.got_q[1], 9'h05a);
    cmp(serial_tx_override_o, 1'b0);
    chk(RA, 8'h40, 8'h40);
    wr(RA, 8'h40);
    chk(RA, 8'h40, 8'h00);
  endtask
  task automatic t_size5();
    peer_u.got_q.delete();
    peer_u.nbits = 5;
    wr(RC, 8'h00);
    wr(RB, 8'h18);
    wr(RD, 8'hff);
    peer_u.send(9'h0ff, 1'b0, 1'b0, 1'b1);
    repeat (2 * BIT) @(posedge core_clk_i);
    cmp(peer_u.got_q[0], 9'h01f);
    chk(RD, 8'hff, 8'h1f);
  endtask
  // Four frames: two fill the FIFO, the fourth start overruns
  task automatic t_fifo();
    peer_u.nbits = 8;
    wr(RC, 8'h06);
    for (int i = 1; i < 5; i++) peer_u.send(9'(i * 8'h11), 1'b0, 1'b0, 1'b1);
    chk(RA, 8'h88, 8'h88);
    chk(RD, 8'hff, 8'h11);
    chk(RD, 8'hff, 8'h22);
    chk(RD, 8'hff, 8'h44);
    chk(RA, 8'h88, 8'h00);
  endtask
  task automatic t_err();
    wr(RC, 8'h26);
    peer_u.send(9'h055, 1'b1, 1'b1, 1'b1);
    peer_u.send(9'h066, 1'b1, 1'b0, 1'b0);
    chk(RA, 8'h14, 8'h04);
    chk(RD, 8'hff, 8'h55);
    chk(RA, 8'h14, 8'h10);
    wr(RB, 8'h08);
    chk(RA, 8'h9c, 8'h00);
    cmp(serial_rx_override_o, 1'b0);
  endtask
  task automatic t_mpcm();
    wr(RC, 8'h06);
    wr(RB, 8'h98);
    wr(RA, 8'h01);
    global_irq_en_i <= 1'b1;
    peer_u.send(9'h077, 1'b0, 1'b0, 1'b0);
    peer_u.send(9'h078, 1'b0, 1'b0, 1'b1);
    cmp(rx_complete_irq_o, 1'b1);
    chk(RD, 8'hff, 8'h78);
    chk(RA, 8'h80, 8'h00);
    global_irq_en_i <= 1'b0;
    wr(RA, 8'h00);
  endtask
  // Clock falls mid-bit, so the receiver samples on falling edges
  task automatic t_sync();
    wr(RC, 8'h46);
    fork
      peer_u.send(9'h0c3, 1'b0, 1'b0, 1'b1);
      repeat (22) begin
        sync_clock_pin_i <= ~sync_clock_pin_i;
        repeat (BIT / 2) @(posedge core_clk_i);
      end
    join
    chk(RD, 8'hff, 8'hc3);
  endtask
  task automatic t_irq();
    wr(RB, 8'he0);
    repeat (3) @(posedge core_clk_i);
    cmp(tx_empty_irq_o, 1'b0);
    global_irq_en_i <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    cmp(tx_empty_irq_o, 1'b1);
    cmp(tx_complete_irq_o, 1'b1);
    cmp(rx_complete_irq_o, 1'b0);
    tx_complete_irq_ack_i <= 1'b1;
    @(posedge core_clk_i);
    tx_complete_irq_ack_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    cmp(tx_complete_irq_o, 1'b0);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge core_clk_i);
    fails++;
    stop_test();
  end
  initial begin
    repeat (12) @(posedge core_clk_i);
    reset_n_i <= 1'b1;
    @(posedge core_clk_i);
    t_regs();
    t_tx();
    t_size5();
    t_fifo();
    t_err();
    t_mpcm();
    t_sync();
    t_irq();
    stop_test();
  end
endmodule
